/* test/mcid_core_props.sv */
// Concurrent checks on the decode and sequencing core
`timescale 1ns/100ps
module mcid_core_props
	import mcid_pkg::*;
#(
	parameter int MC_CLKS = 12
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] pc_o,
	input wire logic [7:0] opcode_o,
	input wire logic [7:0] op1_o,
	input wire logic [7:0] op2_o,
	input wire mcid_cls_e op_class_o,
	input wire logic [2:0] reg_sel_o,
	input wire logic instr_done_o,
	input wire logic branch_o,
	input wire logic bit_clear_o,
	input wire logic load_valid_o,
	input wire logic ext_rd_strobe_n_o,
	input wire logic ext_wr_strobe_n_o,
	input wire logic ext_data_oe_n_o
);
	logic [7:0] low_cnt_reg;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Counts clocks a strobe has been low
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			low_cnt_reg <= 8'h00;
		else if (!ext_rd_strobe_n_o || !ext_wr_strobe_n_o)
			low_cnt_reg <= low_cnt_reg + 8'h01;
		else
			low_cnt_reg <= 8'h00;
	end
	sequence s_xfer_end;
		$rose(ext_rd_strobe_n_o && ext_wr_strobe_n_o);
	endsequence
	sequence s_done(mcid_cls_e c);
		instr_done_o && op_class_o == c;
	endsequence
	a_done_single: assert property (
		instr_done_o |=> !instr_done_o [*5])
		else $error("done pulse too close");
	a_branch_done: assert property (
		branch_o |-> instr_done_o)
		else $error("branch without done");
	a_clear_taken: assert property (
		bit_clear_o |-> branch_o && opcode_o == 8'h10)
		else $error("bit clear misplaced");
	a_load_done: assert property (
		load_valid_o |-> instr_done_o &&
		op_class_o inside {CLS_CODE_LD, CLS_XRD})
		else $error("load valid misplaced");
	a_strobe_width: assert property (
		s_xfer_end |-> low_cnt_reg == MC_CLKS - 3)
		else $error("strobe width wrong");
	a_read_load: assert property (
		$rose(ext_rd_strobe_n_o) |-> ##[0:1] load_valid_o)
		else $error("read without load");
	a_write_oe: assert property (
		!ext_wr_strobe_n_o |-> !ext_data_oe_n_o)
		else $error("write without bus drive");
	a_reg_select: assert property (
		instr_done_o |-> reg_sel_o == opcode_o[2:0])
		else $error("register select wrong");
	a_long_target: assert property (
		s_done(CLS_LONG_JMP) |-> pc_o == {op1_o, op2_o})
		else $error("long target wrong");
	a_page_target: assert property (
		s_done(CLS_PAGE_JMP) or s_done(CLS_PAGE_CALL) |->
		pc_o[10:0] == {opcode_o[7:5], op1_o} &&
		pc_o[15:11] == 5'(($past(pc_o) + 16'h0002) >> 11))
		else $error("page target wrong");
	a_rel_target: assert property (
		s_done(CLS_REL_JMP) |->
		pc_o == $past(pc_o) + 16'h0002 + {{8{op1_o[7]}}, op1_o})
		else $error("relative target wrong");
endmodule // mcid_core_props

/* test/mcid_core_tb.sv */
// Self-checking bench for the decode and sequencing core
`timescale 1ns/100ps
module mcid_core_tb;
	import mcid_pkg::*;
	localparam int MC = 6;
	localparam logic [7:0] OPS [55] = '{8'h00, 8'ha5, 8'h02, 8'h12,
		8'h22, 8'h32, 8'h01, 8'h11, 8'h21, 8'h31, 8'he1, 8'hf1, 8'h80,
		8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h10, 8'hb4, 8'hb5,
		8'hb6, 8'hb7, 8'hb8, 8'hbf, 8'hd5, 8'hd8, 8'hdf, 8'h73, 8'h93,
		8'h83, 8'hf0, 8'he0, 8'hf2, 8'he2, 8'hf3, 8'he3, 8'h90, 8'hc0,
		8'hd0, 8'hd6, 8'hd7, 8'hc5, 8'hc6, 8'hc8, 8'h82, 8'hb0, 8'h72,
		8'ha0, 8'ha2, 8'h92, 8'hc2, 8'hd2, 8'hb2};
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] code_data_i, ext_data_i, acc_i, src_a_i, src_b_i, wv;
	logic carry_i, bit_i, code_rd_o, ind_sel_o, instr_done_o, branch_o;
	logic bit_clear_o, load_valid_o, ext_rd_strobe_n_o, ext_wr_strobe_n_o;
	logic ext_data_oe_n_o, call_o;
	logic [15:0] data_pointer_i, ret_addr_i, code_addr_o, pc_o, imm16_o, pc;
	logic [15:0] xram_addr_o, link_addr_o;
	logic [7:0] opcode_o, op1_o, op2_o, load_data_o, ext_data_o;
	logic [2:0] reg_sel_o;
	mcid_cls_e op_class_o;
	logic [31:0] seed = 32'h080e_a3d5;
	logic [75:0] q [$];
	int errors = 0;
	int n_checks = 0;
	int cnt = 0;
	int ticks = 0;
	mcid_core #(.MC_CLKS(MC)) mcid_core_i (.*);
	mcid_mem_model mcid_mem_model_i (
		.ref_clk_i(ref_clk_i),
		.code_rd_i(code_rd_o),
		.code_addr_i(code_addr_o),
		.xram_addr_i(xram_addr_o),
		.rd_n_i(ext_rd_strobe_n_o),
		.wr_n_i(ext_wr_strobe_n_o),
		.oe_n_i(ext_data_oe_n_o),
		.wdata_i(ext_data_o),
		.code_data_o(code_data_i),
		.ext_data_o(ext_data_i)
	);
	always #25 ref_clk_i = ~ref_clk_i;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [75:0] seen, input logic [75:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Places one instruction, predicts its outcome, waits for its end
	task automatic step(input logic [7:0] op);
		logic [31:0] r, s;
		logic [15:0] nx, tg, la;
		logic [7:0] off, ld;
		logic [1:0] len;
		logic tk, cl, lv;
		int cy;
		r = xs();
		s = xs();
		// Nonzero offsets so a taken branch always moves
		r[0] = 1'b1;
		r[8] = 1'b1;
		acc_i = r[29] ? 8'h00 : r[23:16];
		carry_i = r[27];
		bit_i = r[28];
		ret_addr_i = s[31:16];
		// Reads reuse the address of the write before them
		if (!(op inside {8'he0, 8'he2, 8'he3}))
		begin
			src_a_i = r[24] ? r[31:24] : 8'h01;
			data_pointer_i = s[15:0];
		end
		src_b_i = r[26] ? src_a_i : s[23:16];
		if (r[25] && op inside {[8'hb4:8'hbf]})
			r[7:0] = src_a_i;
		len = 2'd2;
		if (op inside {8'h00, 8'ha5, 8'h22, 8'h32, 8'h73, 8'h93, 8'h83,
			8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3, 8'hd6, 8'hd7,
			8'hc6, 8'hc7, [8'hc8:8'hcf]})
			len = 2'd1;
		if (op inside {8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h90, 8'hd5,
			[8'hb4:8'hbf]})
			len = 2'd3;
		cy = op inside {8'h00, 8'ha5, 8'hd6, 8'hd7, 8'hc5, 8'hc6, 8'hc7,
			[8'hc8:8'hcf], 8'ha2, 8'hc2, 8'hd2, 8'hb2} ? 1 : 2;
		mcid_mem_model_i.code[pc] = op;
		nx = pc + 16'h0001;
		mcid_mem_model_i.code[nx] = r[7:0];
		nx = nx + 16'h0001;
		mcid_mem_model_i.code[nx] = r[15:8];
		nx = pc + 16'(len);
		off = len == 2'd2 ? r[7:0] : r[15:8];
		tg = nx + {{8{off[7]}}, off};
		tk = 1'b0;
		case (op) inside
			8'h02, 8'h12:
			begin
				tk = 1'b1;
				tg = {r[7:0], r[15:8]};
			end
			8'h22, 8'h32:
			begin
				tk = 1'b1;
				tg = ret_addr_i;
			end
			8'h73:
			begin
				tk = 1'b1;
				tg = data_pointer_i + 16'(acc_i);
			end
			8'h80: tk = 1'b1;
			8'h40: tk = carry_i;
			8'h50: tk = !carry_i;
			8'h60: tk = acc_i == 8'h00;
			8'h70: tk = acc_i != 8'h00;
			8'h10, 8'h20: tk = bit_i;
			8'h30: tk = !bit_i;
			8'hd5, [8'hd8:8'hdf]: tk = src_a_i != 8'h01;
			8'hb5: tk = src_a_i != src_b_i;
			[8'hb4:8'hbf]: tk = src_a_i != r[7:0];
			default: tk = 1'b0;
		endcase
		if (op[3:0] == 4'h1)
		begin
			tk = 1'b1;
			tg = {nx[15:11], op[7:5], r[7:0]};
		end
		cl = op == 8'h12 || (op[3:0] == 4'h1 && op[4]);
		la = 16'(acc_i) + (op == 8'h93 ? data_pointer_i : pc + 16'h0001);
		lv = op inside {8'h93, 8'h83, 8'he0, 8'he2, 8'he3};
		ld = op[6] ? wv : mcid_mem_model_i.code[la];
		if (op inside {8'hf0, 8'hf2, 8'hf3})
			wv = acc_i;
		q.push_back({tk ? tg : nx, tk, op == 8'h10 && bit_i, cl,
			cl ? nx : 16'h0000, lv, lv ? ld : 8'h00, 8'(cy * MC), op,
			(op == 8'h90) ? {r[7:0], r[15:8]} : 16'h0000});
		pc = tk ? tg : nx;
		resetn_i = 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			#2;
		end
		while (instr_done_o !== 1'b1);
	endtask
	always @(posedge ref_clk_i)
	begin
		#1;
		ticks++;
		if (ticks == 20000)
		begin
			errors++;
			print_verdict();
		end
		cnt = resetn_i ? cnt + 1 : 0;
		if (instr_done_o === 1'b1)
		begin
			check({pc_o, branch_o, bit_clear_o, call_o,
				call_o ? link_addr_o : 16'h0000, load_valid_o,
				load_valid_o ? load_data_o : 8'h00, 8'(cnt), opcode_o,
				(opcode_o == 8'h90) ? imm16_o : 16'h0000},
				q.size() > 0 ? q.pop_front() : '1);
			cnt = 0;
		end
	end
	initial
	begin
		{acc_i, src_a_i, src_b_i, carry_i, bit_i, data_pointer_i, ret_addr_i} = '0;
		wv = 8'h00;
		pc = 16'h0000;
		for (int a = 0; a < 65536; a++)
			mcid_mem_model_i.code[a] = 8'(a * 7);
		repeat (2) @(posedge ref_clk_i);
		#2;
		for (int i = 0; i < 440; i++)
			step(OPS[i % 55]);
		print_verdict();
	end
endmodule // mcid_core_tb
bind mcid_core mcid_core_props #(.MC_CLKS(MC_CLKS)) mcid_core_props_i (.*);

/* test/mcid_mem_model.sv */
// Program and external data memory on the core's far side
`timescale 1ns/100ps
module mcid_mem_model (
	input wire logic ref_clk_i,
	input wire logic code_rd_i,
	input wire logic [15:0] code_addr_i,
	input wire logic [15:0] xram_addr_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic oe_n_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] code_data_o,
	output logic [7:0] ext_data_o
);
	logic [7:0] code [0:65535];
	logic [7:0] xram [0:65535];
	logic [7:0] idle_reg = 8'h5a;
	// The core samples the byte on the clock after asking for it
	assign code_data_o = code_rd_i ? code[code_addr_i] : ~idle_reg;
	always @(posedge ref_clk_i)
	begin
		// Idle bus keeps changing, never the last byte
		idle_reg <= ~idle_reg;
		if (!wr_n_i)
			xram[xram_addr_i] <= oe_n_i ? idle_reg : wdata_i;
	end
	assign ext_data_o = rd_n_i ? idle_reg : xram[xram_addr_i];
endmodule // mcid_mem_model

/* verilog/mcid_consts.svh */
// Constants for the instruction decode and sequencing block
// Function
// - Code byte load, one byte, two cycles.
// - External RAM move forms, one byte, two cycles.
// - Stack push/pop, two bytes, two cycles.
// - Low digit exchange swaps low nibble, one cycle.
// - Carry and/or with bit, two bytes, two cycles.
// - Bit to carry one cycle; reverse two.
// - Bit operand selects flag, pin or control bit.
// - Eleven-bit target stays inside current 2K page.
// - Long call/jump: three bytes, full 64K reach.
// - Relative target is next address plus signed offset.
// - Sixteen-bit constant sits in bytes two and three.
// - Low opcode bits select working or indirect register.
// - Direct operand selects RAM, port or register.
// - Zero and carry jumps: two bytes, two cycles.
// - Bit-test jumps three bytes; set-clear clears bit.
// - Compare jump branches when operands differ.
// - Decrement jump branches on nonzero result.
// - Indirect jump goes to accumulator plus data pointer.
// - Relative jump always taken, two bytes, two cycles.
// - Accumulator swap forms take one cycle.
// - Read/write strobes pulse low during external transfer.
`ifndef MCID_CONSTS_SVH
`define MCID_CONSTS_SVH
`define MCID_MC_CLKS 12
`define MCID_PC_RESET 16'h0000
`define MCID_OP_LONG_JUMP 8'h02
`define MCID_OP_LONG_CALL 8'h12
`define MCID_OP_BSC 8'h10
`define MCID_OP_BIT 8'h20
`define MCID_OP_NBIT 8'h30
`define MCID_OP_CY 8'h40
`define MCID_OP_NCY 8'h50
`define MCID_OP_ZERO 8'h60
`define MCID_OP_NZERO 8'h70
`define MCID_OP_REL 8'h80
`define MCID_OP_CMP_DIR 8'hB5
`define MCID_OP_RESERVED 8'hA5
`define MCID_DEC_ONE 8'h01
`endif

/* verilog/mcid_core.sv */
// Instruction fetch, decode and control-flow sequencing core
`timescale 1ns/100ps
`include "mcid_consts.svh"

module mcid_core
	import mcid_pkg::*;
#(
	parameter int MC_CLKS = `MCID_MC_CLKS
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] code_data_i,
	input wire logic [7:0] acc_i,
	input wire logic carry_i,
	input wire logic bit_i,
	input wire logic [7:0] src_a_i,
	input wire logic [7:0] src_b_i,
	input wire logic [15:0] data_pointer_i,
	input wire logic [15:0] ret_addr_i,
	input wire logic [7:0] ext_data_i,
	output logic [15:0] code_addr_o,
	output logic code_rd_o,
	output logic [15:0] pc_o,
	output logic [7:0] opcode_o,
	output logic [7:0] op1_o,
	output logic [7:0] op2_o,
	output logic [15:0] imm16_o,
	output mcid_cls_e op_class_o,
	output logic [2:0] reg_sel_o,
	output logic ind_sel_o,
	output logic instr_done_o,
	output logic branch_o,
	output logic bit_clear_o,
	output logic [7:0] load_data_o,
	output logic load_valid_o,
	output logic [15:0] xram_addr_o,
	output logic ext_rd_strobe_n_o,
	output logic ext_wr_strobe_n_o,
	output logic [7:0] ext_data_o,
	output logic ext_data_oe_n_o,
	output logic call_o,
	output logic [15:0] link_addr_o
);

	////////////////////////////////////////////////////////////////////
	// Opcode table: class, byte count and machine cycles
	function automatic mcid_dec_s decode(input logic [7:0] op);
		mcid_dec_s d;
		logic [3:0] hi = op[7:4];
		logic [3:0] lo = op[3:0];
		d.cls = CLS_PLAIN;
		d.len = 2'd1;
		d.cyc = 3'd1;
		if (lo >= 4'h6)
		begin
			if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA)
				d.len = 2'd2;
			if (hi == 4'h8 || hi == 4'hA)
				d.cyc = 3'd2;
			if (hi == 4'hB)
			begin
				d.cls = CLS_CMP_JMP;
				d.len = 2'd3;
				d.cyc = 3'd2;
			end
			if (hi == 4'hC)
				d.cls = CLS_SWAP_ACC;
			if (hi == 4'hD && lo >= 4'h8)
			begin
				d.cls = CLS_DEC_JMP;
				d.len = 2'd2;
				d.cyc = 3'd2;
			end
			if (hi == 4'hD && lo < 4'h8)
				d.cls = CLS_LOW_XCHG;
		end
		else if (lo == 4'h1)
		begin
			// page jumps on even rows, page calls on odd
			d.cls = op[4] ? CLS_PAGE_CALL : CLS_PAGE_JMP;
			d.len = 2'd2;
			d.cyc = 3'd2;
		end
		else
		begin
			if (lo == 4'h4 && hi >= 4'h2 && hi <= 4'h9 && hi != 4'h8)
				d.len = 2'd2;
			if (lo == 4'h5)
				d.len = 2'd2;
			case (op)
				8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'hD5, 8'hB4, 8'hB5,
				8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90:
				begin
					d.len = 2'd3;
					d.cyc = 3'd2;
				end
				8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h72, 8'h82,
				8'hA0, 8'hB0, 8'h92, 8'hC0, 8'hD0:
				begin
					d.len = 2'd2;
					d.cyc = 3'd2;
				end
				8'hA2, 8'hB2, 8'hC2, 8'hD2, 8'h42, 8'h52, 8'h62:
					d.len = 2'd2;
				8'h84, 8'hA4:
					d.cyc = 3'd4;
				8'h22, 8'h32, 8'h73, 8'h83, 8'h93, 8'hA3, 8'hE0, 8'hE2,
				8'hE3, 8'hF0, 8'hF2, 8'hF3:
					d.cyc = 3'd2;
				default:
					d.cyc = 3'd1;
			endcase
			case (op)
				8'h02: d.cls = CLS_LONG_JMP;
				8'h12: d.cls = CLS_LONG_CALL;
				8'h10, 8'h20, 8'h30: d.cls = CLS_BIT_JMP;
				8'h40, 8'h50, 8'h60, 8'h70: d.cls = CLS_COND_JMP;
				8'h80: d.cls = CLS_REL_JMP;
				8'h72, 8'h82, 8'hA0, 8'hB0: d.cls = CLS_BIT_LOGIC;
				8'hA2: d.cls = CLS_BIT_TO_C;
				8'h92: d.cls = CLS_C_TO_BIT;
				// clear, set, complement of a bit
				8'hB2, 8'hC2, 8'hD2: d.cls = CLS_BIT_OP;
				8'hC0: d.cls = CLS_PUSH;
				8'hD0: d.cls = CLS_POP;
				8'hC5: d.cls = CLS_SWAP_ACC;
				8'hB4, 8'hB5: d.cls = CLS_CMP_JMP;
				8'hD5: d.cls = CLS_DEC_JMP;
				8'h73: d.cls = CLS_IND_JMP;
				8'h83, 8'h93: d.cls = CLS_CODE_LD;
				8'h90: d.cls = CLS_DP_LOAD;
				8'hE0, 8'hE2, 8'hE3: d.cls = CLS_XRD;
				8'hF0, 8'hF2, 8'hF3: d.cls = CLS_XWR;
				8'h22, 8'h32: d.cls = CLS_RET;
				`MCID_OP_RESERVED:
				begin
					d.cls = CLS_RESERVED;
					d.len = 2'd1;
				end
				default: d.cls = d.cls;
			endcase
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Sequencer
	mcid_state_s r_reg;
	mcid_state_s r_next;
	mcid_dec_s dec_now;
	logic [7:0] last_cnt;
	logic [15:0] next_pc;
	logic [7:0] offset;
	logic [15:0] rel_target;
	logic taken;
	assign dec_now = (r_reg.bidx == 2'd0) ? decode(code_data_i) : r_reg.dec;
	assign last_cnt = 8'(int'(r_reg.dec.cyc) * MC_CLKS - 1);
	// offset is relative to the following instruction
	assign next_pc = r_reg.pc + {14'h0000, r_reg.dec.len};
	assign offset = (r_reg.dec.len == 2'd3) ? r_reg.op2 : r_reg.op1;
	assign rel_target = next_pc + {{8{offset[7]}}, offset};
	always_comb
	begin
		taken = 1'b0;
		case (r_reg.dec.cls)
			CLS_REL_JMP, CLS_PAGE_JMP, CLS_PAGE_CALL, CLS_LONG_JMP,
			CLS_LONG_CALL, CLS_IND_JMP, CLS_RET:
				taken = 1'b1;
			CLS_COND_JMP:
				case (r_reg.opcode)
					`MCID_OP_CY: taken = carry_i;
					`MCID_OP_NCY: taken = !carry_i;
					`MCID_OP_ZERO: taken = (acc_i == 8'h00);
					default: taken = (acc_i != 8'h00);
				endcase
			CLS_BIT_JMP:
				taken = (r_reg.opcode == `MCID_OP_NBIT) ? !bit_i : bit_i;
			CLS_CMP_JMP:
				taken = (src_a_i != ((r_reg.opcode == `MCID_OP_CMP_DIR) ?
					src_b_i : r_reg.op1));
			// result nonzero unless operand was one
			CLS_DEC_JMP: taken = (src_a_i != `MCID_DEC_ONE);
			default: taken = 1'b0;
		endcase
	end
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.branch = 1'b0;
		r_next.bit_clear = 1'b0;
		r_next.load_valid = 1'b0;
		r_next.call = 1'b0;
		r_next.cnt = r_reg.cnt + 8'h01;
		case (r_reg.state)
			ST_FETCH:
			begin
				r_next.code_addr = r_reg.pc;
				r_next.code_rd = 1'b1;
				r_next.bidx = 2'd0;
				r_next.state = ST_OPND;
			end
			ST_OPND:
			begin
				if (r_reg.bidx == 2'd0)
				begin
					r_next.opcode = code_data_i;
					r_next.dec = dec_now;
				end
				// bytes two and three hold operands
				if (r_reg.bidx == 2'd1)
					r_next.op1 = code_data_i;
				if (r_reg.bidx == 2'd2)
					r_next.op2 = code_data_i;
				if (r_reg.bidx + 2'd1 < dec_now.len)
				begin
					r_next.bidx = r_reg.bidx + 2'd1;
					r_next.code_addr = r_reg.code_addr + 16'h0001;
				end
				else
				begin
					r_next.code_rd = 1'b0;
					r_next.state = ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				if (r_reg.cnt == 8'(MC_CLKS))
				begin
					r_next.wdata = acc_i;
					r_next.xaddr = (r_reg.opcode[1]) ?
						{8'h00, src_a_i} : data_pointer_i;
					r_next.code_addr = {8'h00, acc_i} +
						(r_reg.opcode[4] ? data_pointer_i : next_pc);
					r_next.code_rd = (r_reg.dec.cls == CLS_CODE_LD);
					// Drive the bus a clock before the strobe falls
					r_next.data_oe_n = (r_reg.dec.cls != CLS_XWR);
				end
				if (r_reg.cnt == 8'(MC_CLKS + 1))
				begin
					r_next.code_rd = 1'b0;
					if (r_reg.dec.cls == CLS_CODE_LD)
						r_next.load_data = code_data_i;
					// strobes fall inside the second cycle
					r_next.ext_rd_n = (r_reg.dec.cls != CLS_XRD);
					r_next.ext_wr_n = (r_reg.dec.cls != CLS_XWR);
				end
				if (r_reg.cnt == 8'(2 * MC_CLKS - 2))
				begin
					// data sampled before read strobe rises
					if (r_reg.dec.cls == CLS_XRD)
						r_next.load_data = ext_data_i;
					r_next.ext_rd_n = 1'b1;
					r_next.ext_wr_n = 1'b1;
				end
				if (r_reg.cnt == last_cnt)
				begin
					r_next.done = 1'b1;
					r_next.data_oe_n = 1'b1;
					r_next.cnt = 8'h00;
					r_next.state = ST_FETCH;
					r_next.load_valid = (r_reg.dec.cls == CLS_CODE_LD) ||
						(r_reg.dec.cls == CLS_XRD);
					r_next.branch = taken;
					case (r_reg.dec.cls)
						// upper five bits kept from next address
						CLS_PAGE_JMP, CLS_PAGE_CALL:
							r_next.pc = {next_pc[15:11], r_reg.opcode[7:5],
								r_reg.op1};
						CLS_LONG_JMP, CLS_LONG_CALL:
							r_next.pc = {r_reg.op1, r_reg.op2};
						CLS_IND_JMP:
							r_next.pc = {8'h00, acc_i} + data_pointer_i;
						CLS_RET:
							r_next.pc = ret_addr_i;
						default:
							r_next.pc = taken ? rel_target : next_pc;
					endcase
					// clear bit only when set and taken
					r_next.bit_clear = taken &&
						(r_reg.opcode == `MCID_OP_BSC);
					r_next.call = (r_reg.dec.cls == CLS_PAGE_CALL) ||
						(r_reg.dec.cls == CLS_LONG_CALL);
					r_next.link_addr = next_pc;
				end
			end
			default:
			begin
				r_next.state = ST_FETCH;
				r_next.cnt = 8'h00;
			end
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			r_reg <= '0;
			r_reg.state <= ST_FETCH;
			r_reg.pc <= `MCID_PC_RESET;
			r_reg.ext_rd_n <= 1'b1;
			r_reg.ext_wr_n <= 1'b1;
			r_reg.data_oe_n <= 1'b1;
			r_reg.dec.len <= 2'd1;
			r_reg.dec.cyc <= 3'd1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all taken from the state register
	assign code_addr_o = r_reg.code_addr;
	assign code_rd_o = r_reg.code_rd;
	assign pc_o = r_reg.pc;
	assign opcode_o = r_reg.opcode;
	assign op1_o = r_reg.op1;
	assign op2_o = r_reg.op2;
	assign imm16_o = {r_reg.op1, r_reg.op2};
	assign op_class_o = r_reg.dec.cls;
	// register fields straight from opcode bits
	assign reg_sel_o = r_reg.opcode[2:0];
	assign ind_sel_o = r_reg.opcode[0];
	assign instr_done_o = r_reg.done;
	assign branch_o = r_reg.branch;
	assign bit_clear_o = r_reg.bit_clear;
	assign load_data_o = r_reg.load_data;
	assign load_valid_o = r_reg.load_valid;
	assign xram_addr_o = r_reg.xaddr;
	assign ext_rd_strobe_n_o = r_reg.ext_rd_n;
	assign ext_wr_strobe_n_o = r_reg.ext_wr_n;
	assign ext_data_o = r_reg.wdata;
	assign ext_data_oe_n_o = r_reg.data_oe_n;
	assign call_o = r_reg.call;
	assign link_addr_o = r_reg.link_addr;

endmodule // mcid_core

/* verilog/mcid_pkg.sv */
// Types shared by the instruction decode and sequencing block
package mcid_pkg;

	typedef enum logic [4:0] {
		CLS_PLAIN, CLS_CODE_LD, CLS_XRD, CLS_XWR, CLS_PUSH, CLS_POP,
		CLS_LOW_XCHG, CLS_SWAP_ACC, CLS_BIT_LOGIC, CLS_BIT_TO_C,
		CLS_C_TO_BIT, CLS_BIT_OP, CLS_PAGE_JMP, CLS_PAGE_CALL,
		CLS_LONG_JMP, CLS_LONG_CALL, CLS_REL_JMP, CLS_COND_JMP,
		CLS_BIT_JMP, CLS_CMP_JMP, CLS_DEC_JMP, CLS_IND_JMP,
		CLS_DP_LOAD, CLS_RET, CLS_RESERVED
	} mcid_cls_e;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_OPND = 3'b010,
		ST_EXEC = 3'b100
	} mcid_st_e;

	typedef struct packed {
		mcid_cls_e cls;
		logic [1:0] len;
		logic [2:0] cyc;
	} mcid_dec_s;

	typedef struct packed {
		mcid_st_e state;
		logic [7:0] cnt;
		logic [1:0] bidx;
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] op2;
		mcid_dec_s dec;
		logic [15:0] pc;
		logic [15:0] code_addr;
		logic code_rd;
		logic done;
		logic branch;
		logic bit_clear;
		logic [7:0] load_data;
		logic load_valid;
		logic ext_rd_n;
		logic ext_wr_n;
		logic data_oe_n;
		logic [7:0] wdata;
		logic [15:0] xaddr;
		logic [15:0] link_addr;
		logic call;
	} mcid_state_s;

endpackage
